// [logic/range_pkg.sv]
/*
 * Shared constants for the memory-type range lookup block: type encodings,
 * fixed-region geometry, register offsets, field positions and reset values.
 * Assumes a 32-bit physical address and a 32-bit classic Wishbone register bus.
 */
package range_pkg;
	typedef logic [7:0] mem_type_t;

	// type encodings; the field is eight bits wide
	localparam mem_type_t UNCACHEABLE_TYPE = 8'h00;
	localparam mem_type_t WRITE_COMBINING_TYPE = 8'h01;
	localparam mem_type_t WRITE_THROUGH_TYPE = 8'h04;
	localparam mem_type_t WRITE_BACK_TYPE = 8'h06;

	// fixed-region geometry of the first megabyte
	localparam int FIX64_COUNT = 8;
	localparam int FIX16_COUNT = 16;
	localparam int FIX4_COUNT = 64;
	localparam int FIX_COUNT = FIX64_COUNT + FIX16_COUNT + FIX4_COUNT;
	localparam int FIX_WORDS = FIX_COUNT / 4;
	localparam logic [31:0] FIX16_START = 32'h0008_0000;
	localparam logic [31:0] FIX4_START = 32'h000C_0000;
	localparam logic [31:0] FIRST_MEG_END = 32'h0010_0000;
	localparam int GRAN_LSB = 12;
	localparam int LARGE_LSB = 22;

	// register byte offsets
	localparam logic [11:0] OFS_CAP = 12'h000;
	localparam logic [11:0] OFS_DEF = 12'h004;
	localparam logic [11:0] OFS_CTRL = 12'h008;
	localparam logic [11:0] OFS_PDBR = 12'h00C;
	localparam logic [11:0] OFS_CFLUSH = 12'h010;
	localparam logic [11:0] OFS_STATUS = 12'h014;
	localparam logic [11:0] OFS_VAR = 12'h100;
	localparam logic [11:0] OFS_FIX = 12'h200;

	// field positions
	localparam int CAP_FIX_BIT = 8;
	localparam int CAP_COMBINE_BIT = 10;
	localparam int DEF_FIXED_EN_BIT = 10;
	localparam int DEF_E_BIT = 11;
	localparam int MASK_V_BIT = 11;
	localparam int CTRL_NOCACHE_BIT = 0;
	localparam int CTRL_NOTHRU_BIT = 1;
	localparam int CTRL_GPE_BIT = 2;
	localparam int STATUS_TLB_LSB = 8;

	// defaults
	localparam int PAIRS_DEFAULT = 8;
	localparam int TLB_DEPTH_DEFAULT = 8;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// [logic/range_cfg_if.sv]
/*
 * Carries the programmed range settings from the register owner to the
 * type resolvers. Assumes one owner drives every signal.
 */
`timescale 1ns/1ps
`default_nettype none
interface range_cfg_if #(parameter int NPAIRS = range_pkg::PAIRS_DEFAULT);
	import range_pkg::*;
	mem_type_t default_type;
	logic ranges_on;
	logic fixed_on;
	logic [7:0] pair_count;
	logic [NPAIRS-1:0][19:0] base;
	logic [NPAIRS-1:0][19:0] mask;
	mem_type_t [NPAIRS-1:0] pair_type;
	logic [NPAIRS-1:0] valid;
	mem_type_t [FIX_COUNT-1:0] fixed_type;
	modport owner(output default_type, ranges_on, fixed_on, pair_count, base, mask,
		pair_type, valid, fixed_type);
	modport reader(input default_type, ranges_on, fixed_on, pair_count, base, mask,
		pair_type, valid, fixed_type);
endinterface
`default_nettype wire

// [logic/range_resolver.sv]
/*
 * Combinational memory-type resolver for one physical address.
 * Assumes the settings on the interface are stable while being read.
 */
`timescale 1ns/1ps
`default_nettype none
module range_resolver #(
	parameter int NPAIRS = range_pkg::PAIRS_DEFAULT
) (
	// settings
	range_cfg_if.reader cfg,
	// query
	input wire logic [31:0] addr,
	output range_pkg::mem_type_t mtype,
	output logic fixed_uniform
);
	import range_pkg::*;

	always_comb begin
		int fidx;
		logic hit;
		logic uncached_hit;
		mem_type_t first;
		logic [19:0] gran;
		fidx = 0;
		hit = 1'b0;
		uncached_hit = 1'b0;
		first = UNCACHEABLE_TYPE;
		gran = addr[31:GRAN_LSB];
		if (addr < FIX16_START) begin
			fidx = int'(addr[18:16]);
		end else if (addr < FIX4_START) begin
			fidx = FIX64_COUNT + int'(addr[17:14]);
		end else begin
			fidx = FIX64_COUNT + FIX16_COUNT + int'(addr[17:12]);
		end
		for (int i = 0; i < NPAIRS; i++) begin
			if (i < int'(cfg.pair_count) && cfg.valid[i]
					&& ((gran & cfg.mask[i]) == (cfg.base[i] & cfg.mask[i]))) begin
				if (!hit) begin
					first = cfg.pair_type[i];
				end
				hit = 1'b1;
				if (cfg.pair_type[i] == UNCACHEABLE_TYPE) begin
					uncached_hit = 1'b1;
				end
			end
		end
		if (!cfg.ranges_on) begin
			mtype = UNCACHEABLE_TYPE;
		// fixed only when supported and enabled
		end else if (cfg.fixed_on && addr < FIRST_MEG_END) begin
			mtype = cfg.fixed_type[fidx];
		end else if (hit) begin
			mtype = uncached_hit ? UNCACHEABLE_TYPE : first;
		end else begin
			mtype = cfg.default_type;
		end
		fixed_uniform = 1'b1;
		for (int k = 1; k < FIX_COUNT; k++) begin
			if (cfg.fixed_type[k] != cfg.fixed_type[0]) begin
				fixed_uniform = 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [logic/range_lookup.sv]
/*
 * Memory-type range registers with a small TLB that caches the resolved type.
 * Assumes a classic Wishbone master on the register port and paging logic on
 * the same clock issuing fill and lookup requests.
 */
`timescale 1ns/1ps
`default_nettype none
module range_lookup #(
	parameter int NPAIRS = range_pkg::PAIRS_DEFAULT,
	parameter int TLB_DEPTH = range_pkg::TLB_DEPTH_DEFAULT,
	parameter bit FIX_SUPPORTED = 1'b1,
	parameter bit COMBINE_SUPPORTED = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// translation fill
	input wire logic fill_req,
	input wire logic [31:0] fill_vaddr,
	input wire logic [31:0] fill_paddr,
	input wire logic fill_large,
	input wire logic fill_global,
	output logic fill_done,
	output logic fill_split,
	output range_pkg::mem_type_t fill_type,
	// translation lookup
	input wire logic look_req,
	input wire logic [31:0] look_vaddr,
	output logic look_done,
	output logic look_hit,
	output logic [31:0] look_paddr,
	output range_pkg::mem_type_t look_type,
	// cache control
	output logic no_fill_mode,
	output logic cache_flush,
	output logic tlb_flushed
);
	import range_pkg::*;

	localparam int IDX_W = (TLB_DEPTH > 1) ? $clog2(TLB_DEPTH) : 1;

	typedef struct packed {
		logic valid;
		logic pinned;
		logic big;
		logic [19:0] vpn;
		logic [19:0] ppn;
		mem_type_t mtype;
	} tlb_entry_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		mem_type_t def_type;
		logic fixed_ranges_enable;
		logic range_enable;
		logic cache_disable_flag;
		logic not_write_through_flag;
		logic global_page_enable;
		logic [19:0] pdbr;
		logic [NPAIRS-1:0][19:0] base;
		logic [NPAIRS-1:0][19:0] mask;
		mem_type_t [NPAIRS-1:0] ptype;
		logic [NPAIRS-1:0] pvalid;
		mem_type_t [FIX_COUNT-1:0] fixed;
		tlb_entry_t [TLB_DEPTH-1:0] tlb;
		logic [IDX_W-1:0] victim;
		logic fdone;
		logic fsplit;
		mem_type_t ftype;
		logic ldone;
		logic lhit;
		logic [31:0] lpaddr;
		mem_type_t ltype;
		logic nofill;
		logic cflush;
		logic flushed;
	} state_t;

	state_t s;
	state_t next_s;
	logic rst_meta;
	logic rst_n;
	mem_type_t fill_mtype;
	mem_type_t meg_mtype;
	logic uniform;

	range_cfg_if #(.NPAIRS(NPAIRS)) cfg();

	assign cfg.default_type = s.def_type;
	assign cfg.ranges_on = s.range_enable;
	assign cfg.fixed_on = FIX_SUPPORTED && s.fixed_ranges_enable;
	assign cfg.pair_count = 8'(NPAIRS);
	assign cfg.base = s.base;
	assign cfg.mask = s.mask;
	assign cfg.pair_type = s.ptype;
	assign cfg.valid = s.pvalid;
	assign cfg.fixed_type = s.fixed;

	range_resolver #(.NPAIRS(NPAIRS)) u_fill_res (
		.cfg(cfg.reader),
		.addr(fill_paddr),
		.mtype(fill_mtype),
		.fixed_uniform(uniform)
	);

	// type just above the fixed area, what a large page there would carry
	range_resolver #(.NPAIRS(NPAIRS)) u_meg_res (
		.cfg(cfg.reader),
		.addr(FIRST_MEG_END),
		.mtype(meg_mtype),
		.fixed_uniform()
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = val[8*b +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	always_comb begin
		logic [11:0] off;
		logic [31:0] rd;
		logic [31:0] wv;
		logic [31:0] old;
		logic conflict;
		logic flush_local;
		logic flush_global;
		int vi;
		int fw;
		tlb_entry_t ent;
		next_s = s;
		off = {adr_i[11:2], 2'b00};
		rd = REG_RESET;
		old = REG_RESET;
		wv = REG_RESET;
		conflict = 1'b0;
		flush_local = 1'b0;
		flush_global = 1'b0;
		vi = 0;
		fw = 0;
		ent = '0;
		next_s.fdone = 1'b0;
		next_s.ldone = 1'b0;
		next_s.cflush = 1'b0;
		next_s.flushed = 1'b0;

		// current register image for reads and byte merges
		if (off == OFS_CAP) begin
			rd[7:0] = 8'(NPAIRS);
			rd[CAP_FIX_BIT] = FIX_SUPPORTED;
			rd[CAP_COMBINE_BIT] = COMBINE_SUPPORTED;
		end else if (off == OFS_DEF) begin
			rd[7:0] = s.def_type;
			rd[DEF_FIXED_EN_BIT] = s.fixed_ranges_enable;
			rd[DEF_E_BIT] = s.range_enable;
		end else if (off == OFS_CTRL) begin
			rd[CTRL_NOCACHE_BIT] = s.cache_disable_flag;
			rd[CTRL_NOTHRU_BIT] = s.not_write_through_flag;
			rd[CTRL_GPE_BIT] = s.global_page_enable;
		end else if (off == OFS_PDBR) begin
			rd[31:GRAN_LSB] = s.pdbr;
		end else if (off == OFS_STATUS) begin
			rd[0] = s.nofill;
			for (int t = 0; t < TLB_DEPTH && t < 24; t++) begin
				rd[STATUS_TLB_LSB + t] = s.tlb[t].valid;
			end
		end else if (off >= OFS_VAR && off < OFS_VAR + 12'(8 * NPAIRS)) begin
			vi = int'((off - OFS_VAR) >> 3);
			if (!off[2]) begin
				rd[31:GRAN_LSB] = s.base[vi];
				rd[7:0] = s.ptype[vi];
			end else begin
				rd[31:GRAN_LSB] = s.mask[vi];
				rd[MASK_V_BIT] = s.pvalid[vi];
			end
		end else if (off >= OFS_FIX && off < OFS_FIX + 12'(4 * FIX_WORDS)) begin
			fw = int'((off - OFS_FIX) >> 2);
			rd = {s.fixed[4*fw+3], s.fixed[4*fw+2], s.fixed[4*fw+1], s.fixed[4*fw]};
		end
		old = rd;
		wv = merge(old, dat_i, sel_i);

		// bus: ack one cycle after request, write commits on the ack edge
		if (cyc_i && stb_i && !s.ack) begin
			next_s.ack = 1'b1;
			next_s.rdata = rd;
		end else begin
			next_s.ack = 1'b0;
		end
		if (cyc_i && stb_i && s.ack && we_i) begin
			if (off == OFS_DEF) begin
				next_s.def_type = wv[7:0];
				next_s.fixed_ranges_enable = wv[DEF_FIXED_EN_BIT];
				next_s.range_enable = wv[DEF_E_BIT];
			end else if (off == OFS_CTRL) begin
				next_s.cache_disable_flag = wv[CTRL_NOCACHE_BIT];
				next_s.not_write_through_flag = wv[CTRL_NOTHRU_BIT];
				next_s.global_page_enable = wv[CTRL_GPE_BIT];
				if (s.global_page_enable && !wv[CTRL_GPE_BIT]) begin
					flush_global = 1'b1;
				end
			end else if (off == OFS_PDBR) begin
				next_s.pdbr = wv[31:GRAN_LSB];
				// any base write flushes, even same value
				flush_local = 1'b1;
				flush_global = !s.global_page_enable;
			end else if (off == OFS_CFLUSH) begin
				next_s.cflush = 1'b1;
			end else if (off >= OFS_VAR && off < OFS_VAR + 12'(8 * NPAIRS)) begin
				if (!off[2]) begin
					next_s.base[vi] = wv[31:GRAN_LSB];
					next_s.ptype[vi] = wv[7:0];
				end else begin
					next_s.mask[vi] = wv[31:GRAN_LSB];
					next_s.pvalid[vi] = wv[MASK_V_BIT];
				end
			end else if (off >= OFS_FIX && off < OFS_FIX + 12'(4 * FIX_WORDS)) begin
				for (int b = 0; b < 4; b++) begin
					next_s.fixed[4*fw+b] = wv[8*b +: 8];
				end
			end
		end

		next_s.nofill = next_s.cache_disable_flag && !next_s.not_write_through_flag;

		// large page over the first megabyte, fixed types disagree
		conflict = fill_large && fill_paddr[31:LARGE_LSB] == '0 && cfg.fixed_on
			&& s.range_enable && !(uniform && s.fixed[0] == meg_mtype);
		if (fill_req) begin
			ent.valid = 1'b1;
			ent.pinned = fill_global;
			// resolved type kept in the entry
			ent.mtype = fill_mtype;
			// split into a 4-KByte entry for the touched granule
			if (conflict || !fill_large) begin
				ent.big = 1'b0;
				ent.vpn = fill_vaddr[31:GRAN_LSB];
				ent.ppn = fill_paddr[31:GRAN_LSB];
			end else begin
				ent.big = 1'b1;
				ent.vpn = {fill_vaddr[31:LARGE_LSB], 10'h000};
				ent.ppn = {fill_paddr[31:LARGE_LSB], 10'h000};
			end
			next_s.tlb[s.victim] = ent;
			next_s.victim = s.victim + 1'b1;
			next_s.fdone = 1'b1;
			next_s.fsplit = conflict;
			next_s.ftype = fill_mtype;
		end

		if (flush_local || flush_global) begin
			next_s.flushed = 1'b1;
			for (int t = 0; t < TLB_DEPTH; t++) begin
				if (flush_global || !next_s.tlb[t].pinned) begin
					next_s.tlb[t].valid = 1'b0;
				end
			end
		end

		if (look_req) begin
			next_s.ldone = 1'b1;
			next_s.lhit = 1'b0;
			next_s.lpaddr = REG_RESET;
			next_s.ltype = UNCACHEABLE_TYPE;
			for (int t = TLB_DEPTH - 1; t >= 0; t--) begin
				if (s.tlb[t].valid && (s.tlb[t].big
						? s.tlb[t].vpn[19:10] == look_vaddr[31:LARGE_LSB]
						: s.tlb[t].vpn == look_vaddr[31:GRAN_LSB])) begin
					next_s.lhit = 1'b1;
					next_s.ltype = s.tlb[t].mtype;
					next_s.lpaddr = s.tlb[t].big
						? {s.tlb[t].ppn[19:10], look_vaddr[LARGE_LSB-1:0]}
						: {s.tlb[t].ppn, look_vaddr[GRAN_LSB-1:0]};
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign dat_o = s.rdata;
	assign ack_o = s.ack;
	assign fill_done = s.fdone;
	assign fill_split = s.fsplit;
	assign fill_type = s.ftype;
	assign look_done = s.ldone;
	assign look_hit = s.lhit;
	assign look_paddr = s.lpaddr;
	assign look_type = s.ltype;
	assign no_fill_mode = s.nofill;
	assign cache_flush = s.cflush;
	assign tlb_flushed = s.flushed;
endmodule
`default_nettype wire

// [test/range_lookup_chk.sv]
/*
 * Port checker for range_lookup, bound onto every instance.
 * Assumes one clock, the register bus held until ack and aligned addresses.
 */
`timescale 1ns/1ps
`default_nettype none
module range_lookup_chk
	import range_pkg::*;
(
	// clock and bus
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	// paging side
	input wire logic fill_req,
	input wire logic fill_large,
	input wire logic fill_done,
	input wire logic fill_split,
	input wire range_pkg::mem_type_t fill_type,
	input wire logic look_done,
	input wire logic look_hit,
	input wire logic [31:0] look_paddr,
	input wire range_pkg::mem_type_t look_type,
	// cache side
	input wire logic no_fill_mode,
	input wire logic cache_flush,
	input wire logic tlb_flushed
);
	logic wr_ack;
	logic en;
	logic nf;
	assign wr_ack = ack_o && we_i && cyc_i && stb_i;
	// shadow of the enable and mode bits, updated at the write's ack edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en <= 1'b0;
			nf <= 1'b0;
		end else if (wr_ack && adr_i == OFS_DEF && sel_i[1]) begin
			en <= dat_i[DEF_E_BIT];
		end else if (wr_ack && adr_i == OFS_CTRL && sel_i[0]) begin
			nf <= dat_i[CTRL_NOCACHE_BIT] && !dat_i[CTRL_NOTHRU_BIT];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	property p_fill_done; fill_req |=> fill_done; endproperty
	property p_miss; look_done && !look_hit |-> look_paddr == 32'h0 && look_type == 8'h00; endproperty
	property p_off; fill_done && !$past(en) |-> fill_type == UNCACHEABLE_TYPE; endproperty
	property p_split; fill_done && fill_split |-> $past(fill_large) && $past(en); endproperty
	property p_nofill; wr_ack && adr_i == OFS_CTRL |=> ##1 no_fill_mode == nf; endproperty
	property p_cache_flush; wr_ack && adr_i == OFS_CFLUSH |=> cache_flush ##1 !cache_flush; endproperty
	property p_flush; wr_ack && adr_i == OFS_PDBR |=> tlb_flushed ##1 !tlb_flushed; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("ack late");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	a_fill_done: assert property (p_fill_done) else $error("fill not done");
	a_miss: assert property (p_miss) else $error("miss data not zero");
	a_off: assert property (p_off) else $error("type not uncacheable");
	a_split: assert property (p_split) else $error("bad split");
	a_nofill: assert property (p_nofill) else $error("no-fill mode wrong");
	a_cache_flush: assert property (p_cache_flush) else $error("no cache flush pulse");
	a_flush: assert property (p_flush) else $error("no tlb flush pulse");
	c_split: cover property (fill_done && fill_split);
	c_hit: cover property (look_done && look_hit);
	c_cache_flush: cover property (cache_flush);
endmodule
bind range_lookup range_lookup_chk i_chk (
	.clk(clk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .fill_req(fill_req), .fill_large(fill_large),
	.fill_done(fill_done), .fill_split(fill_split), .fill_type(fill_type),
	.look_done(look_done), .look_hit(look_hit), .look_paddr(look_paddr),
	.look_type(look_type), .no_fill_mode(no_fill_mode), .cache_flush(cache_flush),
	.tlb_flushed(tlb_flushed)
);
`default_nettype wire

// [test/paging_agent.sv]
/*
 * Paging-side partner: issues translation fills and lookups as pulses.
 * Assumes the bench calls its tasks just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module paging_agent (
	// clock
	input wire logic clk,
	// fill
	output logic fill_req,
	output logic [31:0] fill_vaddr,
	output logic [31:0] fill_paddr,
	output logic fill_large,
	output logic fill_global,
	input wire logic fill_done,
	// lookup
	output logic look_req,
	output logic [31:0] look_vaddr,
	input wire logic look_done,
	output var int timeouts
);
	initial begin
		fill_req = 1'b0;
		fill_vaddr = 32'h0;
		fill_paddr = 32'h0;
		fill_large = 1'b0;
		fill_global = 1'b0;
		look_req = 1'b0;
		look_vaddr = 32'h0;
		timeouts = 0;
	end
	task automatic wait_done(input bit f);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((f ? fill_done : look_done) !== 1'b1 && n < 4);
		if (n == 4) timeouts++;
	endtask
	// released address lines are scrambled so stale values never help
	task automatic fill(input logic [31:0] v, input logic [31:0] p, input logic lg, input logic gl);
		fill_req <= 1'b1;
		fill_vaddr <= v;
		fill_paddr <= p;
		fill_large <= lg;
		fill_global <= gl;
		@(posedge clk);
		fill_req <= 1'b0;
		fill_vaddr <= ~v;
		fill_paddr <= ~p;
		wait_done(1'b1);
	endtask
	task automatic look(input logic [31:0] v);
		look_req <= 1'b1;
		look_vaddr <= v;
		@(posedge clk);
		look_req <= 1'b0;
		look_vaddr <= ~v;
		wait_done(1'b0);
	endtask
endmodule
`default_nettype wire

// [test/memory_type_range_lookup_test.sv]
/*
 * Bench for range_lookup with a shadow model of ranges and TLB.
 * Assumes the paging_agent partner and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
module memory_type_range_lookup_test;
	import range_pkg::*;
	typedef struct {logic [31:0] t, p; bit l, g; mem_type_t y;} ent_t;
	logic clk, reset_n, cyc_i, stb_i, we_i, ack_o, fill_req, fill_large, fill_global, fill_done;
	logic fill_split, look_req, look_done, look_hit, no_fill_mode, cache_flush, tlb_flushed;
	logic [11:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, fill_vaddr, fill_paddr, look_vaddr, look_paddr, rd, a;
	mem_type_t fill_type, look_type, dt, fx[88], vt[8];
	mem_type_t tys[4] = '{8'h00, 8'h01, 8'h04, 8'h06};
	logic [31:0] lv[6] = '{32'h4000_0123, 32'h4000_5000, 32'h4087_6543, 32'h5000_3ABC,
		32'h5000_5004, 32'h6000_0000};
	logic [19:0] vb[8], vm[8];
	bit vv[8], e, fxen, gpe;
	ent_t q[$];
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int tmo;
	range_lookup i_dut (
		.clk(clk), .reset_n(reset_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.fill_req(fill_req), .fill_vaddr(fill_vaddr), .fill_paddr(fill_paddr),
		.fill_large(fill_large), .fill_global(fill_global), .fill_done(fill_done),
		.fill_split(fill_split), .fill_type(fill_type), .look_req(look_req),
		.look_vaddr(look_vaddr), .look_done(look_done), .look_hit(look_hit),
		.look_paddr(look_paddr), .look_type(look_type), .no_fill_mode(no_fill_mode),
		.cache_flush(cache_flush), .tlb_flushed(tlb_flushed)
	);
	paging_agent i_agent (
		.clk(clk), .fill_req(fill_req), .fill_vaddr(fill_vaddr), .fill_paddr(fill_paddr),
		.fill_large(fill_large), .fill_global(fill_global), .fill_done(fill_done),
		.look_req(look_req), .look_vaddr(look_vaddr), .look_done(look_done), .timeouts(tmo)
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		failures += tmo;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic bus_xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= ad;
		sel_i <= 4'hF;
		dat_i <= d;
		// only the bench cycle ceiling ends a wait that never sees ack
		do begin
			@(posedge clk);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
		bus_xfer(1'b0, ad, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		int i;
		bus_xfer(1'b1, ad, d);
		i = int'((ad - OFS_VAR) >> 3);
		if (ad >= OFS_FIX) begin
			for (int b = 0; b < 4; b++) fx[int'(ad - OFS_FIX) + b] = d[8*b +: 8];
		end else if (ad >= OFS_VAR && ad[2]) begin
			vm[i] = d[31:12];
			vv[i] = d[11];
		end else if (ad >= OFS_VAR) begin
			vb[i] = d[31:12];
			vt[i] = d[7:0];
		end else if (ad == OFS_DEF) begin
			dt = d[7:0];
			fxen = d[10];
			e = d[11];
		end else if (ad == OFS_CTRL) begin
			if (gpe && !d[2]) q.delete();
			gpe = d[2];
		end else if (ad == OFS_PDBR) begin
			for (int k = q.size() - 1; k >= 0; k--) if (!(gpe && q[k].g)) q.delete(k);
		end
	endtask
	function automatic mem_type_t res(input logic [31:0] x);
		bit hit, unc;
		mem_type_t t;
		hit = 0;
		unc = 0;
		t = dt;
		if (!e) return 8'h00;
		if (fxen && x < FIRST_MEG_END) begin
			if (x < FIX16_START) return fx[x[18:16]];
			if (x < FIX4_START) return fx[8 + int'((x - FIX16_START) >> 14)];
			return fx[24 + int'((x - FIX4_START) >> 12)];
		end
		for (int i = 0; i < 8; i++) begin
			if (vv[i] && (x[31:12] & vm[i]) == (vb[i] & vm[i])) begin
				if (!hit) t = vt[i];
				hit = 1;
				if (vt[i] == 8'h00) unc = 1;
			end
		end
		return unc ? 8'h00 : t;
	endfunction
	task automatic fchk(input logic [31:0] v, input logic [31:0] p, input bit lg, input bit gl);
		ent_t n;
		bit uni, sp;
		mem_type_t t;
		uni = 1;
		for (int k = 1; k < FIX_COUNT; k++) if (fx[k] !== fx[0]) uni = 0;
		t = res(p);
		sp = lg && p[31:22] == 0 && e && fxen && (!uni || fx[0] !== res(FIRST_MEG_END));
		i_agent.fill(v, p, lg, gl);
		chk(32'(fill_type), 32'(t));
		chk(32'(fill_split), 32'(sp));
		n.l = lg && !sp;
		n.t = n.l ? v >> LARGE_LSB : v >> GRAN_LSB;
		n.p = p;
		n.g = gl;
		n.y = t;
		q.push_back(n);
	endtask
	task automatic lchk(input logic [31:0] v);
		logic [31:0] xp;
		mem_type_t xt;
		bit h;
		h = 0;
		xp = 32'h0;
		xt = 8'h00;
		foreach (q[k]) if (q[k].t == (q[k].l ? v >> LARGE_LSB : v >> GRAN_LSB)) begin
			h = 1;
			xt = q[k].y;
			xp = q[k].l ? {q[k].p[31:22], v[21:0]} : {q[k].p[31:12], v[11:0]};
		end
		i_agent.look(v);
		chk(32'(look_hit), 32'(h));
		chk(look_paddr, xp);
		chk(32'(look_type), 32'(xt));
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		reset_n = 1'b0;
		{cyc_i, stb_i, we_i} = 3'h0;
		adr_i = 12'h0;
		sel_i = 4'hF;
		dat_i = 32'h0;
		{e, fxen, gpe} = 3'h0;
		dt = 8'h00;
		vv = '{default: 0};
		fx = '{default: 8'h00};
		void'($urandom(32'h47E2));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(OFS_CAP, 32'h0000_0508);
		wr(OFS_CAP, 32'hFFFF_FFFF);
		rchk(OFS_CAP, 32'h0000_0508);
		rchk(12'h050, 32'h0);
		rchk(OFS_DEF, 32'h0);
		wr(OFS_CTRL, 32'h1);
		rchk(OFS_STATUS, 32'h1);
		wr(OFS_CFLUSH, 32'h0);
		wr(OFS_PDBR, 32'h0);
		wr(OFS_DEF, 32'h0);
		fchk(32'h0001_0000, 32'h0001_0000, 0, 0);
		wr(12'h100, 32'h0000_0006);
		wr(12'h104, 32'hFC00_0800);
		wr(12'h108, 32'h0400_0000);
		wr(12'h10C, 32'hFFC0_0800);
		wr(12'h110, 32'h0400_0006);
		wr(12'h114, 32'hFFC0_0800);
		wr(12'h118, 32'h1000_0004);
		wr(12'h11C, 32'hFF00_0000);
		wr(12'h138, 32'hA000_0001);
		wr(12'h13C, 32'hFF80_0800);
		for (int w = 0; w < FIX_WORDS; w++) begin
			for (int b = 0; b < 4; b++) a[8*b +: 8] = tys[$urandom % 4];
			wr(OFS_FIX + 12'(4 * w), a);
		end
		wr(OFS_DEF, 32'h0000_0C04);
		wr(OFS_CFLUSH, 32'h0);
		wr(OFS_PDBR, 32'h0);
		wr(OFS_CTRL, 32'h0);
		// one pair toggled by its valid bit
		wr(12'h13C, 32'hFF80_0000);
		fchk(32'hA000_2000, 32'hA000_2000, 0, 0);
		wr(12'h13C, 32'hFF80_0800);
		for (int ph = 0; ph < 2; ph++) begin
			wr(OFS_DEF, ph ? 32'h0000_0804 : 32'h0000_0C04);
			repeat (24) begin
				a = $urandom;
				case ($urandom % 4)
					0: a = a & 32'h000F_FFFF;
					1: a = a & 32'h07FF_FFFF;
					2: a = {4'h1, a[27:0]};
					default: a = {9'h140, a[22:0]};
				endcase
				fchk(a, a, 0, 0);
			end
		end
		wr(OFS_DEF, 32'h0000_0C04);
		wr(OFS_PDBR, 32'h0);
		wr(OFS_CTRL, 32'h4);
		fchk(32'h4000_0000, 32'h0, 1, 1);
		fchk(32'h4080_0000, 32'h0080_0000, 1, 0);
		fchk(32'h5000_3000, 32'h0400_1000, 0, 1);
		fchk(32'h5000_5000, 32'h000C_5000, 0, 0);
		for (int r = 0; r < 3; r++) begin
			foreach (lv[k]) lchk(lv[k]);
			if (r == 0) wr(OFS_PDBR, 32'h0);
			if (r == 1) wr(OFS_CTRL, 32'h0);
		end
		close_out();
	end
endmodule
`default_nettype wire
